//--- jtc_enc8b10b.sv
`timescale 1ns/1ps
module jtc_enc8b10b
  import jtc_pkg::*;
(
  input wire logic [7:0] octet,
  input wire logic is_k,
  input wire logic rd_in,
  output logic [9:0] sym,
  output logic rd_out
);

  // ************************************************************
  // code tables, abcdei and fghj, negative running disparity
  // ************************************************************
  localparam logic [5:0] T6 [32] = '{
    6'h27, 6'h1d, 6'h2d, 6'h31, 6'h35, 6'h29, 6'h19, 6'h38, 6'h39, 6'h25, 6'h15, 6'h34, 6'h0d, 6'h2c, 6'h1c, 6'h17,
    6'h1b, 6'h23, 6'h13, 6'h32, 6'h0b, 6'h2a, 6'h1a, 6'h3a, 6'h33, 6'h26, 6'h16, 6'h36, 6'h0e, 6'h2e, 6'h1e, 6'h2b};
  localparam logic [3:0] T4 [8] = '{4'hb, 4'h9, 4'h5, 4'hc, 4'hd, 4'ha, 4'h6, 4'he};
  localparam logic [3:0] K4 [8] = '{4'h4, 4'h9, 4'h5, 4'h3, 4'h2, 4'ha, 4'h6, 4'h8};
  localparam logic [5:0] K28_6B = 6'h0f;
  localparam logic [3:0] ALT7 = 4'h7;
  localparam logic [4:0] D7 = 5'h07;
  localparam logic [2:0] Y3 = 3'h3;
  localparam logic [2:0] Y7 = 3'h7;

  logic [4:0] x;
  logic [2:0] y;
  logic [5:0] a6;
  logic [3:0] t4;
  logic rd6;
  logic alt;

  always_comb
  begin
    x = octet[4:0];
    y = octet[7:5];
    a6 = T6[x];
    rd6 = rd_in ^ ($countones(a6) != 3);
    alt = (y == Y7) && (rd6 ? (x == 5'h0b || x == 5'h0d || x == 5'h0e) : (x == 5'h11 || x == 5'h12 || x == 5'h14));
    t4 = alt ? ALT7 : T4[y];
    if (is_k)
    begin
      // only the comma family is supported; other k codes go out as k28
      sym = rd_in ? ~{K28_6B, K4[y]} : {K28_6B, K4[y]};
      rd_out = ~rd_in ^ ($countones(K4[y]) != 2);
    end
    else
    begin
      sym[9:4] = (rd_in && ($countones(a6) != 3 || x == D7)) ? ~a6 : a6;
      sym[3:0] = (rd6 && ($countones(t4) != 2 || y == Y3)) ? ~t4 : t4;
      rd_out = rd6 ^ ($countones(t4) != 2);
    end
  end

endmodule // jtc_enc8b10b

//--- jtc_link_test_ctrl.sv
// Operation
// - bypass clear encodes; set sends octet, top bits zero
// - invert set flips all ten symbol bits
// - checksum mode 00 sums table octets
// - checksum mode 01 sums lsb-aligned fields
// - mode 10 sends zero checksum; 11 unused
// - injection 1 at encoder output, 0 at samples
// - injection 10 puts pattern octet before scrambler
// - select 0 passes normal data untouched
// - checkerboard, toggle, ramp, user repeat, user once
// - select 3 gives pn31, x31+x28+1
// - select 4 gives pn23, x23+x18+1
// - select 5 gives pn15, x15+x14+1
// - select 6 gives pn9, x9+x5+1
// - select 7 gives pn7, x7+x6+1
`timescale 1ns/1ps
module jtc_link_test_ctrl
  import jtc_pkg::*;
(
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic [JTC_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [JTC_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [15:0] smp_in,
  output logic [15:0] smp_out,
  input wire logic [7:0] scr_in,
  output logic [7:0] scr_out,
  input wire logic [7:0] enc_in,
  input wire logic enc_k,
  output logic [9:0] sym_out,
  output logic [7:0] csum_out
);

  typedef struct packed {
    logic aw_got;
    logic [JTC_AW-1:0] aw_addr;
    logic w_got;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [7:0] ctrl2;
    logic [7:0] ctrl3;
    logic [15:0] user_pat;
    logic [31:0] cfg0;
    logic [31:0] cfg1;
    logic [31:0] cfg2;
    logic [7:0] csum;
    logic [30:0] lfsr;
    logic [15:0] ramp;
    logic phase;
    logic user_done;
    logic rd;
    logic [15:0] smp_out;
    logic [7:0] scr_out;
    logic [9:0] sym_out;
    logic live;
  } jtc_state_t;

  localparam jtc_state_t JTC_RST = '{awready: 1'b1, wready: 1'b1, arready: 1'b1, lfsr: '1, ctrl2: JTC_CTRL_RST,
    ctrl3: JTC_CTRL_RST, user_pat: JTC_USER_RST, cfg0: JTC_CFG_RST, cfg1: JTC_CFG_RST, cfg2: JTC_CFG_RST, default: '0};

  // ************************************************************
  // helpers
  // ************************************************************
  function automatic jtc_reg_t decode(logic [JTC_AW-1:0] a);
    jtc_reg_t r;
    r = JTC_R_NONE;
    if (a == jtc_addr(JTC_IDX_CTRL2)) r = JTC_R_CTRL2;
    if (a == jtc_addr(JTC_IDX_CTRL3)) r = JTC_R_CTRL3;
    if (a == jtc_addr(JTC_IDX_USER)) r = JTC_R_USER;
    if (a == jtc_addr(JTC_IDX_CFG0)) r = JTC_R_CFG0;
    if (a == jtc_addr(JTC_IDX_CFG1)) r = JTC_R_CFG1;
    if (a == jtc_addr(JTC_IDX_CFG2)) r = JTC_R_CFG2;
    if (a == jtc_addr(JTC_IDX_CSUM)) r = JTC_R_CSUM;
    return r;
  endfunction

  function automatic logic [31:0] merge(logic [31:0] old, logic [31:0] d, logic [3:0] strb);
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++)
      if (strb[i]) m[8*i +: 8] = d[8*i +: 8];
    return m;
  endfunction

  function automatic logic [7:0] csum_bytes(logic [95:0] t);
    logic [7:0] s;
    s = 8'h00;
    for (int i = 0; i < JTC_CFG_OCTETS; i++)
      s = s + t[8*i +: 8];
    return s;
  endfunction

  function automatic logic [7:0] csum_fields(logic [95:0] t);
    logic [7:0] s;
    logic [7:0] o;
    s = 8'h00;
    for (int i = 0; i < JTC_FLD_N; i++)
    begin
      o = t[8*JTC_FLD_OCT[i] +: 8] >> JTC_FLD_LSB[i];
      s = s + (o & 8'((9'h001 << JTC_FLD_W[i]) - 9'h001));
    end
    return s;
  endfunction

  function automatic logic [30:0] pn_step(logic [30:0] s, jtc_pat_t p);
    logic fb;
    fb = 1'b0;
    unique case (p)
      JTC_PAT_PN31: fb = s[JTC_PN31_LEN-1] ^ s[JTC_PN31_TAP-1];
      JTC_PAT_PN23: fb = s[JTC_PN23_LEN-1] ^ s[JTC_PN23_TAP-1];
      JTC_PAT_PN15: fb = s[JTC_PN15_LEN-1] ^ s[JTC_PN15_TAP-1];
      JTC_PAT_PN9: fb = s[JTC_PN9_LEN-1] ^ s[JTC_PN9_TAP-1];
      JTC_PAT_PN7: fb = s[JTC_PN7_LEN-1] ^ s[JTC_PN7_TAP-1];
      default: fb = 1'b0;
    endcase
    return {s[29:0], fb};
  endfunction

  jtc_state_t st;
  jtc_state_t next_st;
  jtc_pat_t sel;
  jtc_inj_t inj;
  jtc_csum_t cmode;
  logic active;
  logic enc_inj;
  logic bypass;
  logic invert;
  logic restart;
  logic [15:0] pat;
  logic [95:0] cfg_tbl;
  logic [9:0] enc_sym;
  logic enc_rd;

  assign sel = jtc_pat_t'(st.ctrl3[JTC_PAT_LSB +: JTC_PAT_W]);
  assign inj = jtc_inj_t'(st.ctrl3[JTC_INJ_LSB +: JTC_INJ_W]);
  assign cmode = jtc_csum_t'(st.ctrl3[JTC_CSUM_LSB +: JTC_CSUM_W]);
  assign active = sel != JTC_PAT_OFF;
  assign enc_inj = active && inj == JTC_INJ_ENC;
  assign bypass = st.ctrl2[JTC_BYPASS_BIT];
  assign invert = st.ctrl2[JTC_INVERT_BIT];
  assign cfg_tbl = {st.cfg2, st.cfg1, st.cfg0};
  // a pattern restarts from its seed whenever its control octet is written
  assign restart = st.aw_got && st.w_got && !st.bvalid && decode(st.aw_addr) == JTC_R_CTRL3 && st.w_strb[0];

  jtc_enc8b10b u_enc (
    .octet(enc_in),
    .is_k(enc_k),
    .rd_in(st.rd),
    .sym(enc_sym),
    .rd_out(enc_rd)
  );

  // ************************************************************
  // pattern word
  // ************************************************************
  always_comb
  begin
    unique case (sel)
      JTC_PAT_CHECKER: pat = st.phase ? JTC_CHECKER_B : JTC_CHECKER_A;
      JTC_PAT_TOGGLE: pat = st.phase ? JTC_TOGGLE_ZERO : JTC_TOGGLE_ONE;
      JTC_PAT_PN31: pat = st.lfsr[15:0];
      JTC_PAT_PN23: pat = st.lfsr[15:0];
      JTC_PAT_PN15: pat = 16'(st.lfsr[JTC_PN15_LEN-1:0]);
      JTC_PAT_PN9: pat = 16'(st.lfsr[JTC_PN9_LEN-1:0]);
      JTC_PAT_PN7: pat = 16'(st.lfsr[JTC_PN7_LEN-1:0]);
      JTC_PAT_RAMP: pat = st.ramp;
      JTC_PAT_USER_REP: pat = st.user_pat;
      JTC_PAT_USER_ONE: pat = st.user_done ? JTC_TOGGLE_ZERO : st.user_pat;
      default: pat = JTC_TOGGLE_ZERO;
    endcase
  end

  // ************************************************************
  // next state
  // ************************************************************
  always_comb
  begin
    logic [9:0] sym;
    logic [31:0] wv;
    sym = 10'h000;
    wv = 32'h0000_0000;
    next_st = st;
    next_st.live = 1'b1;
    if (s_axi_awvalid && st.awready)
    begin
      next_st.aw_got = 1'b1;
      next_st.aw_addr = s_axi_awaddr;
      next_st.awready = 1'b0;
    end
    if (s_axi_wvalid && st.wready)
    begin
      next_st.w_got = 1'b1;
      next_st.w_data = s_axi_wdata;
      next_st.w_strb = s_axi_wstrb;
      next_st.wready = 1'b0;
    end
    if (st.aw_got && st.w_got && !st.bvalid)
    begin
      next_st.bvalid = 1'b1;
      next_st.bresp = JTC_RESP_OKAY;
      unique case (decode(st.aw_addr))
        JTC_R_CTRL2:
        begin
          wv = merge({24'h0, st.ctrl2}, st.w_data, st.w_strb);
          next_st.ctrl2 = wv[7:0] & JTC_CTRL2_WMASK;
        end
        JTC_R_CTRL3:
        begin
          wv = merge({24'h0, st.ctrl3}, st.w_data, st.w_strb);
          next_st.ctrl3 = wv[7:0];
        end
        JTC_R_USER:
        begin
          wv = merge({16'h0, st.user_pat}, st.w_data, st.w_strb);
          next_st.user_pat = wv[15:0];
        end
        JTC_R_CFG0: next_st.cfg0 = merge(st.cfg0, st.w_data, st.w_strb);
        JTC_R_CFG1: next_st.cfg1 = merge(st.cfg1, st.w_data, st.w_strb);
        JTC_R_CFG2: next_st.cfg2 = merge(st.cfg2, st.w_data, st.w_strb);
        JTC_R_CSUM: next_st.bresp = JTC_RESP_OKAY;
        JTC_R_NONE: next_st.bresp = JTC_RESP_SLVERR;
      endcase
    end
    if (st.bvalid && s_axi_bready)
    begin
      next_st.bvalid = 1'b0;
      next_st.aw_got = 1'b0;
      next_st.w_got = 1'b0;
      next_st.awready = 1'b1;
      next_st.wready = 1'b1;
    end
    if (s_axi_arvalid && st.arready)
    begin
      next_st.arready = 1'b0;
      next_st.rvalid = 1'b1;
      next_st.rresp = JTC_RESP_OKAY;
      unique case (decode(s_axi_araddr))
        JTC_R_CTRL2: next_st.rdata = {24'h0, st.ctrl2};
        JTC_R_CTRL3: next_st.rdata = {24'h0, st.ctrl3};
        JTC_R_USER: next_st.rdata = {16'h0, st.user_pat};
        JTC_R_CFG0: next_st.rdata = st.cfg0;
        JTC_R_CFG1: next_st.rdata = st.cfg1;
        JTC_R_CFG2: next_st.rdata = st.cfg2;
        JTC_R_CSUM: next_st.rdata = {24'h0, st.csum};
        JTC_R_NONE:
        begin
          next_st.rdata = 32'h0000_0000;
          next_st.rresp = JTC_RESP_SLVERR;
        end
      endcase
    end
    if (st.rvalid && s_axi_rready)
    begin
      next_st.rvalid = 1'b0;
      next_st.arready = 1'b1;
    end
    // checksum tracks the table every cycle, so a write shows one cycle later
    unique case (cmode)
      JTC_CS_BYTES: next_st.csum = csum_bytes(cfg_tbl);
      JTC_CS_FIELDS: next_st.csum = csum_fields(cfg_tbl);
      JTC_CS_ZERO: next_st.csum = 8'h00;
      default: next_st.csum = 8'h00;
    endcase
    if (restart)
    begin
      next_st.lfsr = '1;
      next_st.ramp = 16'h0000;
      next_st.phase = 1'b0;
      next_st.user_done = 1'b0;
    end
    else
    begin
      next_st.lfsr = pn_step(st.lfsr, sel);
      next_st.ramp = st.ramp + JTC_RAMP_STEP;
      next_st.phase = ~st.phase;
      next_st.user_done = st.user_done || sel == JTC_PAT_USER_ONE;
    end
    next_st.smp_out = (active && inj == JTC_INJ_SAMPLE) ? pat : smp_in;
    next_st.scr_out = (active && inj == JTC_INJ_SCR) ? pat[7:0] : scr_in;
    if (enc_inj)
      sym = pat[9:0];
    else if (bypass)
      sym = {2'h0, enc_in};
    else
    begin
      sym = enc_sym;
      next_st.rd = enc_rd;
    end
    next_st.sym_out = invert ? ~sym : sym;
  end

  always_ff @(posedge core_clk)
  begin
    if (!rstn)
      st <= JTC_RST;
    else
      st <= next_st;
  end

  assign s_axi_awready = st.awready;
  assign s_axi_wready = st.wready;
  assign s_axi_bvalid = st.bvalid;
  assign s_axi_bresp = st.bresp;
  assign s_axi_arready = st.arready;
  assign s_axi_rvalid = st.rvalid;
  assign s_axi_rresp = st.rresp;
  assign s_axi_rdata = st.rdata;
  assign smp_out = st.smp_out;
  assign scr_out = st.scr_out;
  assign sym_out = st.sym_out;
  assign csum_out = st.csum;

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge core_clk);
  endclocking
  // live keeps checks off for the edge at which rstn is released, while outputs still hold reset values
  default disable iff (!rstn || !st.live);

  a_bypass_upper_zero: assert property (bypass && !invert && !enc_inj |=> sym_out == {2'h0, $past(enc_in)})
    else $error("bypass symbol wrong");
  a_enc_balanced: assert property (!bypass && !invert && !enc_inj |=> $countones(sym_out) inside {[4:6]})
    else $error("encoded symbol unbalanced");
  a_invert_all: assert property (bypass && invert && !enc_inj |=> sym_out == ~{2'h0, $past(enc_in)})
    else $error("inverted symbol wrong");
  a_csum_bytes: assert property (cmode == JTC_CS_BYTES |=> csum_out == $past(cfg_tbl[7:0] + cfg_tbl[15:8] +
    cfg_tbl[23:16] + cfg_tbl[31:24] + cfg_tbl[39:32] + cfg_tbl[47:40] + cfg_tbl[55:48] + cfg_tbl[63:56] +
    cfg_tbl[71:64] + cfg_tbl[79:72] + cfg_tbl[87:80]))
    else $error("octet checksum wrong");
  a_csum_fields: assert property (cmode == JTC_CS_FIELDS |=> csum_out == $past(8'(cfg_tbl[7:0] + cfg_tbl[11:8] +
    cfg_tbl[20:16] + cfg_tbl[31] + cfg_tbl[28:24] + cfg_tbl[39:32] + cfg_tbl[44:40] + cfg_tbl[55:48] +
    cfg_tbl[63:62] + cfg_tbl[60:56] + cfg_tbl[71:69] + cfg_tbl[68:64] + cfg_tbl[79:77] + cfg_tbl[76:72] +
    cfg_tbl[87] + cfg_tbl[84:80])))
    else $error("field checksum wrong");
  a_csum_zero: assert property (cmode == JTC_CS_ZERO |=> csum_out == 8'h00)
    else $error("checksum not zero");
  a_smp_inject: assert property (active && inj == JTC_INJ_SAMPLE |=> smp_out == $past(pat))
    else $error("sample injection wrong");
  a_enc_inject: assert property (enc_inj && !invert |=> sym_out == $past(pat[9:0]))
    else $error("symbol injection wrong");
  a_scr_inject: assert property (active && inj == JTC_INJ_SCR |=> scr_out == $past(pat[7:0]))
    else $error("scrambler injection wrong");
  a_normal_pass: assert property (!active |=> smp_out == $past(smp_in) && scr_out == $past(scr_in))
    else $error("normal data altered");
  a_checker_alt: assert property (sel == JTC_PAT_CHECKER && !restart ##1 sel == JTC_PAT_CHECKER
    |-> pat == ~$past(pat) && (pat == JTC_CHECKER_A || pat == JTC_CHECKER_B))
    else $error("checkerboard broken");
  a_ramp_step: assert property (sel == JTC_PAT_RAMP && !restart |=> pat == $past(pat) + JTC_RAMP_STEP)
    else $error("ramp step wrong");
  a_user_once: assert property (sel == JTC_PAT_USER_ONE && !restart |=> pat == 16'h0000)
    else $error("single user pattern repeated");
  a_pn31_poly: assert property (sel == JTC_PAT_PN31 && !restart
    |=> st.lfsr[0] == $past(st.lfsr[30] ^ st.lfsr[27]) && st.lfsr[30:1] == $past(st.lfsr[29:0]))
    else $error("pn31 step wrong");
  a_pn23_poly: assert property (sel == JTC_PAT_PN23 && !restart |=> st.lfsr[0] == $past(st.lfsr[22] ^ st.lfsr[17]))
    else $error("pn23 step wrong");
  a_pn15_poly: assert property (sel == JTC_PAT_PN15 && !restart |=> st.lfsr[0] == $past(st.lfsr[14] ^ st.lfsr[13]))
    else $error("pn15 step wrong");
  a_pn9_poly: assert property (sel == JTC_PAT_PN9 && !restart |=> st.lfsr[0] == $past(st.lfsr[8] ^ st.lfsr[4]))
    else $error("pn9 step wrong");
  a_pn7_poly: assert property (sel == JTC_PAT_PN7 && !restart |=> st.lfsr[0] == $past(st.lfsr[6] ^ st.lfsr[5]))
    else $error("pn7 step wrong");

  c_enc_inject: cover property (enc_inj ##1 enc_inj);
  c_pn31_run: cover property (sel == JTC_PAT_PN31 [*3]);
  c_write_done: cover property (s_axi_bvalid && s_axi_bready);
  c_read_done: cover property (s_axi_rvalid && s_axi_rready);

endmodule // jtc_link_test_ctrl

//--- jtc_link_test_ctrl_tb.sv
`timescale 1ns/1ps
module jtc_link_test_ctrl_tb
  import jtc_pkg::*;
;
  typedef struct {logic [15:0] so, si; logic [7:0] co, ci, e; logic [9:0] y;} jtc_rec_t;
  logic core_clk = 1'b0, rstn = 1'b0, kmode = 1'b0, enc_k = 1'b0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0, s_axi_bready = 1'b1, s_axi_rready = 1'b1;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [JTC_AW-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [15:0] smp_in = 16'h0000, smp_out, comma_cnt, c, u;
  logic [7:0] scr_in = 8'h00, enc_in = 8'h00, scr_out, csum_out;
  logic [9:0] sym_out;
  logic [31:0] cfg [3];
  logic [7:0] oc [12], ex [4];
  int err_total = 0, checks = 0, i, s00, s01;
  int ln [8] = '{0, 0, 0, 31, 23, 15, 9, 7};
  int tp [8] = '{0, 0, 0, 28, 18, 14, 5, 6};
  jtc_rec_t q [$];

  jtc_link_test_ctrl u_jtc_link_test_ctrl (.core_clk, .rstn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .smp_in, .smp_out, .scr_in, .scr_out, .enc_in, .enc_k, .sym_out, .csum_out);
  jtc_rx_model u_jtc_rx_model (.core_clk, .rstn, .sym(sym_out), .comma_cnt);

  always #12.5 core_clk = ~core_clk;

  // *****
  // stimulus and capture
  // *****
  always @(posedge core_clk)
  begin
    q.push_back('{smp_out, smp_in, scr_out, scr_in, enc_in, sym_out});
    smp_in <= 16'($urandom);
    scr_in <= 8'($urandom);
    enc_in <= kmode ? 8'hbc : 8'($urandom);
    enc_k <= kmode;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic tmo(input int n);
    if (n >= 50)
    begin
      err_total++;
      conclude();
    end
  endtask

  task automatic wr(input logic [11:0] idx, input logic [31:0] d, input logic [1:0] er = JTC_RESP_OKAY);
    int n;
    s_axi_awaddr <= {2'h0, idx, 2'h0};
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    n = 0;
    do
    begin
      @(posedge core_clk);
      n++;
      if (s_axi_awvalid && s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end
    while (!s_axi_bvalid && n < 50);
    tmo(n);
    chk(s_axi_bresp, er);
  endtask

  task automatic rd(input logic [11:0] idx, input logic [31:0] v, input logic [1:0] er = JTC_RESP_OKAY);
    int n;
    s_axi_araddr <= {2'h0, idx, 2'h0};
    s_axi_arvalid <= 1'b1;
    n = 0;
    do
    begin
      @(posedge core_clk);
      n++;
      if (s_axi_arvalid && s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end
    while (!s_axi_rvalid && n < 50);
    tmo(n);
    chk(s_axi_rdata, v);
    chk(s_axi_rresp, er);
  endtask

  // skipping 40 samples keeps the 31-deep pn recurrence inside the new pattern
  task automatic ana(input int kind, input logic [15:0] u, input int l, input int t);
    int ones;
    jtc_rec_t p, r;
    ones = 0;
    for (int k = (kind == 15) ? 1 : 40; k < q.size(); k++)
    begin
      p = q[k-1];
      r = q[k];
      case (kind)
        0: chk({r.so, r.co}, {p.si, p.ci});
        1: chk({r.so, r.co}, {p.so === 16'haaaa ? 16'h5555 : 16'haaaa, p.ci});
        2: chk(r.so, p.so === 16'hffff ? 16'h0000 : 16'hffff);
        3: chk(r.so[0], q[k-l].so[0] ^ q[k-t].so[0]);
        8: chk(r.so, p.so + 16'h0001);
        14: chk(r.so, u);
        20: chk({r.so, r.co}, {p.si, p.co === 8'haa ? 8'h55 : 8'haa});
        21: chk(r.y, p.y + 10'h001);
        22: chk(r.y, p.y - 10'h001);
        23: chk(r.y, {2'b00, p.e});
        24: chk(r.y, {2'b11, ~p.e});
        25: chk(r.y, p.y === 10'h0fa ? 10'h305 : 10'h0fa);
        default: ;
      endcase
      ones += (kind == 15) ? int'(r.so === u) : int'(r.so[0]);
    end
    if (kind == 15)
      chk(ones, 1);
    if (kind == 15)
      chk(q[$].so, 16'h0000);
    if (kind == 3)
      chk(ones > 0, 1'b1);
  endtask

  task automatic run(input logic [7:0] c2, c3, input int kind, input logic [15:0] u = 16'h0000,
    input int l = 1, input int t = 1);
    wr(JTC_IDX_CTRL2, {24'h0, c2});
    q.delete();
    wr(JTC_IDX_CTRL3, {24'h0, c3});
    repeat (80) @(posedge core_clk);
    ana(kind, u, l, t);
  endtask

  initial
  begin
    void'($urandom(94281));
    repeat (12) @(posedge core_clk);
    rstn <= 1'b1;
    @(posedge core_clk);
    rd(JTC_IDX_CTRL3, 32'h0000_0000);
    rd(JTC_IDX_CTRL2, 32'h0000_0000);
    wr(JTC_IDX_CTRL2, 32'hffff_ffff);
    rd(JTC_IDX_CTRL2, {24'h0, JTC_CTRL2_WMASK});
    wr(12'h5ff, 32'h0000_00ff, JTC_RESP_SLVERR);
    rd(12'h5ff, 32'h0000_0000, JTC_RESP_SLVERR);
    for (i = 0; i < 3; i++)
    begin
      cfg[i] = $urandom;
      wr(JTC_IDX_CFG0 + 12'(i), cfg[i]);
      rd(JTC_IDX_CFG0 + 12'(i), cfg[i]);
    end
    s00 = 0;
    s01 = 0;
    for (i = 0; i < 12; i++)
      oc[i] = cfg[i / 4][8 * (i % 4) +: 8];
    for (i = 0; i < 11; i++)
      s00 += oc[i];
    for (i = 0; i < JTC_FLD_N; i++)
      s01 += (oc[JTC_FLD_OCT[i]] >> JTC_FLD_LSB[i]) & ((1 << JTC_FLD_W[i]) - 1);
    ex = '{s00[7:0], s01[7:0], 8'h00, 8'h00};
    for (i = 0; i < 4; i++)
    begin
      wr(JTC_IDX_CTRL3, {24'h0, 2'(i), 6'h00});
      wr(JTC_IDX_CSUM, 32'h0000_00ff);
      chk(csum_out, ex[i]);
      rd(JTC_IDX_CSUM, {24'h0, ex[i]});
    end
    u = 16'($urandom) | 16'h0100;
    s_axi_wstrb <= 4'h2;
    wr(JTC_IDX_USER, 32'hffff_ffff);
    s_axi_wstrb <= 4'hf;
    rd(JTC_IDX_USER, 32'h0000_ff00);
    wr(JTC_IDX_USER, {16'h0, u});
    rd(JTC_IDX_USER, {16'h0, u});
    run(8'h00, 8'h00, 0);
    run(8'h00, 8'h01, 1);
    run(8'h00, 8'h02, 2);
    run(8'h00, 8'h08, 8);
    run(8'h00, 8'h0e, 14, u);
    run(8'h00, 8'h00, 0);
    run(8'h00, 8'h0f, 15, u);
    for (i = 3; i < 8; i++)
      run(8'h00, 8'(i), 3, u, ln[i], tp[i]);
    run(8'h00, 8'h21, 20);
    run(8'h00, 8'h18, 21);
    run(8'h02, 8'h18, 22);
    run(8'h04, 8'h00, 23);
    run(8'h06, 8'h00, 24);
    kmode <= 1'b1;
    c = comma_cnt;
    run(8'h00, 8'h00, 25);
    chk(16'(comma_cnt - c) > 16'h003c, 1'b1);
    conclude();
  end
endmodule // jtc_link_test_ctrl_tb

//--- jtc_pkg.sv
package jtc_pkg;

  // ************************************************************
  // register map
  // ************************************************************
  localparam int JTC_AW = 16;
  localparam logic [11:0] JTC_IDX_CTRL2 = 12'h572;
  localparam logic [11:0] JTC_IDX_CTRL3 = 12'h573;
  localparam logic [11:0] JTC_IDX_USER = 12'h580;
  localparam logic [11:0] JTC_IDX_CFG0 = 12'h581;
  localparam logic [11:0] JTC_IDX_CFG1 = 12'h582;
  localparam logic [11:0] JTC_IDX_CFG2 = 12'h583;
  localparam logic [11:0] JTC_IDX_CSUM = 12'h584;
  localparam logic [7:0] JTC_CTRL_RST = 8'h00;
  localparam logic [7:0] JTC_CTRL2_WMASK = 8'h07;
  localparam logic [15:0] JTC_USER_RST = 16'h0000;
  localparam logic [31:0] JTC_CFG_RST = 32'h0000_0000;
  localparam logic [1:0] JTC_RESP_OKAY = 2'h0;
  localparam logic [1:0] JTC_RESP_SLVERR = 2'h2;

  // ************************************************************
  // fields
  // ************************************************************
  localparam int JTC_BYPASS_BIT = 2;
  localparam int JTC_INVERT_BIT = 1;
  localparam int JTC_CSUM_LSB = 6;
  localparam int JTC_CSUM_W = 2;
  localparam int JTC_INJ_LSB = 4;
  localparam int JTC_INJ_W = 2;
  localparam int JTC_PAT_LSB = 0;
  localparam int JTC_PAT_W = 4;

  typedef enum logic [3:0] {
    JTC_PAT_OFF = 4'b0000, JTC_PAT_CHECKER = 4'b0001, JTC_PAT_TOGGLE = 4'b0010,
    JTC_PAT_PN31 = 4'b0011, JTC_PAT_PN23 = 4'b0100, JTC_PAT_PN15 = 4'b0101,
    JTC_PAT_PN9 = 4'b0110, JTC_PAT_PN7 = 4'b0111, JTC_PAT_RAMP = 4'b1000,
    JTC_PAT_USER_REP = 4'b1110, JTC_PAT_USER_ONE = 4'b1111
  } jtc_pat_t;

  typedef enum logic [1:0] {
    JTC_INJ_SAMPLE = 2'b00, JTC_INJ_ENC = 2'b01, JTC_INJ_SCR = 2'b10
  } jtc_inj_t;

  typedef enum logic [1:0] {
    JTC_CS_BYTES = 2'b00, JTC_CS_FIELDS = 2'b01, JTC_CS_ZERO = 2'b10
  } jtc_csum_t;

  typedef enum logic [2:0] {
    JTC_R_NONE = 3'b000, JTC_R_CTRL2 = 3'b001, JTC_R_CTRL3 = 3'b010, JTC_R_USER = 3'b011,
    JTC_R_CFG0 = 3'b100, JTC_R_CFG1 = 3'b101, JTC_R_CFG2 = 3'b110, JTC_R_CSUM = 3'b111
  } jtc_reg_t;

  // ************************************************************
  // patterns
  // ************************************************************
  localparam logic [15:0] JTC_CHECKER_A = 16'haaaa;
  localparam logic [15:0] JTC_CHECKER_B = 16'h5555;
  localparam logic [15:0] JTC_TOGGLE_ONE = 16'hffff;
  localparam logic [15:0] JTC_TOGGLE_ZERO = 16'h0000;
  localparam logic [15:0] JTC_RAMP_STEP = 16'h0001;
  localparam int JTC_PN31_LEN = 31;
  localparam int JTC_PN31_TAP = 28;
  localparam int JTC_PN23_LEN = 23;
  localparam int JTC_PN23_TAP = 18;
  localparam int JTC_PN15_LEN = 15;
  localparam int JTC_PN15_TAP = 14;
  localparam int JTC_PN9_LEN = 9;
  localparam int JTC_PN9_TAP = 5;
  localparam int JTC_PN7_LEN = 7;
  localparam int JTC_PN7_TAP = 6;

  // ************************************************************
  // link configuration table: octet, lsb and width of each field
  // ************************************************************
  localparam int JTC_CFG_OCTETS = 11;
  localparam int JTC_FLD_N = 16;
  localparam int JTC_FLD_OCT [JTC_FLD_N] = '{0, 1, 2, 3, 3, 4, 5, 6, 7, 7, 8, 8, 9, 9, 10, 10};
  localparam int JTC_FLD_LSB [JTC_FLD_N] = '{0, 0, 0, 7, 0, 0, 0, 0, 6, 0, 5, 0, 5, 0, 7, 0};
  localparam int JTC_FLD_W [JTC_FLD_N] = '{8, 4, 5, 1, 5, 8, 5, 8, 2, 5, 3, 5, 3, 5, 1, 5};

  function automatic logic [JTC_AW-1:0] jtc_addr(logic [11:0] idx);
    return {2'h0, idx, 2'h0};
  endfunction

endpackage

//--- jtc_rx_model.sv
`timescale 1ns/1ps
// *****
// far-end receiver
// *****
module jtc_rx_model
(
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic [9:0] sym,
  output logic [15:0] comma_cnt
);
  // counts commas of either disparity; lane alignment is not modelled
  always @(posedge core_clk)
  begin
    if (!rstn)
      comma_cnt <= 16'h0000;
    else if (sym[9:3] == 7'h1f || sym[9:3] == 7'h60)
      comma_cnt <= comma_cnt + 16'h0001;
  end
endmodule // jtc_rx_model
